// *** src/dfm_top.sv ***
/*
 drive fault monitor: latches sticky fault flags from sensor inputs,
 kills motor and pfc pwm on over-current, applies zero-vector braking
 on critical bus over-voltage, and exposes registers over wishbone.
 assumes sensor inputs synchronous to clk_sys and a classic wishbone
 master that holds each request until ack.
*/
`timescale 1ns/1ps
module dfm_top
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// sensors
	input  wire dfm_pkg::dfm_sense_t sense,
	// pwm requests from the modulator
	input  wire logic [2:0]        pwm_hi_req,
	input  wire logic [2:0]        pwm_lo_req,
	input  wire logic [1:0]        pfc_pwm_req,
	// gated pwm and shutdown
	output logic      [2:0]        pwm_hi,
	output logic      [2:0]        pwm_lo,
	output logic      [1:0]        pfc_pwm,
	output logic                   mot_shutdown,
	output logic                   pfc_shutdown
);
	import dfm_pkg::*;

	// sticky flags and their enables
	logic [19:0] flags;
	logic [19:0] enable;

	// threshold and limit registers
	logic [15:0] vdc_hi;
	logic [15:0] vdc_lo;
	logic [15:0] pvdc_hi;
	logic [15:0] pvdc_lo;
	logic [15:0] vcrit;
	logic [15:0] temp_hi;
	logic [15:0] vac_hi;
	logic [15:0] vac_lo;
	logic [15:0] freq_nom;
	logic [31:0] link_to;
	logic [31:0] hall_to;
	logic        hall_mode;

	// watchdog counters and hall history
	logic [31:0] link_cnt;
	logic [31:0] hall_cnt;
	logic [2:0]  hall_prev;

	// fault decode and bus strobes
	logic [19:0] event_now;
	logic [19:0] w1c;
	logic [19:0] active;
	logic        wr_stb;
	logic        rd_stb;
	logic [31:0] wmask;
	logic [31:0] next_rdata;

	// shutdown paths
	logic        mot_trip;
	logic        mot_kill;
	logic        pfc_kill;
	logic        brake;

	// a transfer is taken once per request: ack drops in the next cycle
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// fault conditions sampled every cycle
	always_comb
	begin
		event_now = '0;
		event_now[DFM_B_GKILL]  = sense.mot_oc;
		event_now[DFM_B_CRITOV] = sense.vdc > vcrit;
		event_now[DFM_B_DCOV]   = sense.vdc > vdc_hi;
		event_now[DFM_B_PDCOV]  = sense.pfc_vdc > pvdc_hi;
		event_now[DFM_B_DCUV]   = sense.vdc < vdc_lo;
		event_now[DFM_B_PDCUV]  = sense.pfc_vdc < pvdc_lo;
		event_now[DFM_B_PLL]    = sense.pll_lost;
		event_now[DFM_B_OVTEMP] = sense.temp > temp_hi;
		event_now[DFM_B_RLOCK]  = sense.rotor_lock;
		event_now[DFM_B_EXEC]   = sense.cpu_load > DFM_LOAD_LIMIT;
		event_now[DFM_B_PHLOSS] = sense.phase_open;
		event_now[DFM_B_PARAM]  = sense.par_bad;
		event_now[DFM_B_LINK]   = link_cnt > link_to;
		event_now[DFM_B_HALLIN] = (sense.hall == DFM_HALL_ZERO) |
		                          (sense.hall == DFM_HALL_SEVEN);
		event_now[DFM_B_HALLTO] = hall_mode & (hall_cnt > hall_to);
		event_now[DFM_B_PGKILL] = sense.pfc_oc;
		event_now[DFM_B_PACOV]  = sense.vac > vac_hi;
		event_now[DFM_B_PACUV]  = sense.vac < vac_lo;
		event_now[DFM_B_PFREQ]  = sense.freq != freq_nom;
		event_now[DFM_B_PPARAM] = sense.pfc_par_bad;
	end

	// write-one-to-clear strobes for the flag register
	assign w1c = (wr_stb && wb_adr_i == DFM_OFS_FLAGS) ?
	             (wb_dat_i[19:0] & wmask[19:0]) : '0;

	// sticky flags, one per fault; a new event beats a clear
	genvar gi;
	generate
		for (gi = 0; gi < DFM_NFLT; gi++)
		begin : g_flag
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
					flags[gi] <= 1'b0;
				else if (event_now[gi])
					flags[gi] <= 1'b1;
				else if (w1c[gi])
					flags[gi] <= 1'b0;
			end
		end
	endgenerate

	// faults that reach the shutdown path
	assign active = flags & (enable | DFM_UNMASK);
	// the live condition also kills so the first pwm edge is already off
	assign mot_trip = active[DFM_B_GKILL] | sense.mot_oc;
	assign mot_kill = mot_trip |
	                  (|(active & ~DFM_UNMASK & 20'h0_1FFC));
	assign pfc_kill = active[DFM_B_PGKILL] | sense.pfc_oc |
	                  (|(active & ~DFM_UNMASK & 20'hF_C000));
	// no fault but over-current ends braking; a critical level always comes
	// with a bus window fault, so letting it win would never brake
	assign brake    = (active[DFM_B_CRITOV] | event_now[DFM_B_CRITOV])
	                  & ~mot_trip;

	// uart silence counter, restarted by each received byte
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			link_cnt <= '0;
		else if (sense.uart_rx)
			link_cnt <= '0;
		else if (link_cnt <= link_to)
			link_cnt <= link_cnt + 32'h0000_0001; // saturates past limit
	end

	// hall edge watchdog; only runs in hall mode
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hall_cnt  <= '0;
			hall_prev <= '0;
		end
		else
		begin
			hall_prev <= sense.hall;
			if (!hall_mode || sense.hall != hall_prev)
				hall_cnt <= '0;
			else if (hall_cnt <= hall_to)
				hall_cnt <= hall_cnt + 32'h0000_0001;
		end
	end

	// pwm gating: over-current beats braking, braking beats other faults
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pwm_hi       <= '0;
			pwm_lo       <= '0;
			pfc_pwm      <= '0;
			mot_shutdown <= 1'b0;
			pfc_shutdown <= 1'b0;
		end
		else
		begin
			mot_shutdown <= mot_kill | brake;
			pfc_shutdown <= pfc_kill;
			if (mot_trip)
			begin
				pwm_hi <= '0;
				pwm_lo <= '0;
			end
			else if (brake)
			begin
				pwm_hi <= '0;
				pwm_lo <= 3'h7;
			end
			else if (mot_kill)
			begin
				pwm_hi <= '0;
				pwm_lo <= '0;
			end
			else
			begin
				pwm_hi <= pwm_hi_req;
				pwm_lo <= pwm_lo_req;
			end
			pfc_pwm <= pfc_kill ? 2'h0 : pfc_pwm_req;
		end
	end

	// configuration registers with byte-lane writes
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			enable    <= DFM_RST_ENABLE;
			vdc_hi    <= DFM_RST_MAXLVL;
			vdc_lo    <= DFM_RST_LEVEL;
			pvdc_hi   <= DFM_RST_MAXLVL;
			pvdc_lo   <= DFM_RST_LEVEL;
			vcrit     <= DFM_RST_MAXLVL;
			temp_hi   <= DFM_RST_MAXLVL;
			vac_hi    <= DFM_RST_MAXLVL;
			vac_lo    <= DFM_RST_LEVEL;
			freq_nom  <= DFM_RST_LEVEL;
			link_to   <= DFM_RST_TIMEO;
			hall_to   <= DFM_RST_TIMEO;
			hall_mode <= 1'b0;
		end
		else if (wr_stb)
		begin
			case (wb_adr_i)
				// fault enables, one bit per flag
				DFM_OFS_ENABLE:
					enable <= (enable & ~wmask[19:0]) |
					          (wb_dat_i[19:0] & wmask[19:0]);
				// motor bus window
				DFM_OFS_VDC_HI:
					vdc_hi <= (vdc_hi & ~wmask[15:0]) |
					          (wb_dat_i[15:0] & wmask[15:0]);
				DFM_OFS_VDC_LO:
					vdc_lo <= (vdc_lo & ~wmask[15:0]) |
					          (wb_dat_i[15:0] & wmask[15:0]);
				// pfc bus window
				DFM_OFS_PVDC_HI:
					pvdc_hi <= (pvdc_hi & ~wmask[15:0]) |
					           (wb_dat_i[15:0] & wmask[15:0]);
				DFM_OFS_PVDC_LO:
					pvdc_lo <= (pvdc_lo & ~wmask[15:0]) |
					           (wb_dat_i[15:0] & wmask[15:0]);
				// critical level that starts braking
				DFM_OFS_VCRIT:
					vcrit <= (vcrit & ~wmask[15:0]) |
					         (wb_dat_i[15:0] & wmask[15:0]);
				// temperature level
				DFM_OFS_TEMP_HI:
					temp_hi <= (temp_hi & ~wmask[15:0]) |
					           (wb_dat_i[15:0] & wmask[15:0]);
				// ac window
				DFM_OFS_VAC_HI:
					vac_hi <= (vac_hi & ~wmask[15:0]) |
					          (wb_dat_i[15:0] & wmask[15:0]);
				DFM_OFS_VAC_LO:
					vac_lo <= (vac_lo & ~wmask[15:0]) |
					          (wb_dat_i[15:0] & wmask[15:0]);
				// nominal line frequency, compared for equality
				DFM_OFS_FREQ:
					freq_nom <= (freq_nom & ~wmask[15:0]) |
					            (wb_dat_i[15:0] & wmask[15:0]);
				// watchdog limits in cycles; a partial lane write keeps
				// the other bytes, so a limit can be changed in pieces
				DFM_OFS_LINK_TO:
					link_to <= (link_to & ~wmask) | (wb_dat_i & wmask);
				DFM_OFS_HALL_TO:
					hall_to <= (hall_to & ~wmask) | (wb_dat_i & wmask);
				DFM_OFS_CTRL:
					if (wb_sel_i[0])
						hall_mode <= wb_dat_i[0];
				default:
					hall_mode <= hall_mode; // unmapped writes are dropped
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = '0;
		case (wb_adr_i)
			DFM_OFS_FLAGS:   next_rdata[19:0] = flags;
			DFM_OFS_ENABLE:  next_rdata[19:0] = enable;
			DFM_OFS_VDC_HI:  next_rdata[15:0] = vdc_hi;
			DFM_OFS_VDC_LO:  next_rdata[15:0] = vdc_lo;
			DFM_OFS_PVDC_HI: next_rdata[15:0] = pvdc_hi;
			DFM_OFS_PVDC_LO: next_rdata[15:0] = pvdc_lo;
			DFM_OFS_VCRIT:   next_rdata[15:0] = vcrit;
			DFM_OFS_TEMP_HI: next_rdata[15:0] = temp_hi;
			DFM_OFS_VAC_HI:  next_rdata[15:0] = vac_hi;
			DFM_OFS_VAC_LO:  next_rdata[15:0] = vac_lo;
			DFM_OFS_FREQ:    next_rdata[15:0] = freq_nom;
			DFM_OFS_LINK_TO: next_rdata = link_to;
			DFM_OFS_HALL_TO: next_rdata = hall_to;
			DFM_OFS_CTRL:    next_rdata[0] = hall_mode;
			DFM_OFS_STATUS:  next_rdata[2:0] = {brake, pfc_kill, mot_kill};
			default:         next_rdata = '0;
		endcase
	end

	// one-cycle ack, registered read data
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= wr_stb | rd_stb;
			wb_dat_o <= rd_stb ? next_rdata : '0;
		end
	end

endmodule

// *** src/dfm_pkg.sv ***
/*
 fault monitor package: register map, fault bit layout, reset values,
 sensor carrier struct.
 assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
*/
package dfm_pkg;

	// register byte offsets
	localparam logic [7:0] DFM_OFS_FLAGS   = 8'h00; // sticky fault flags, w1c
	localparam logic [7:0] DFM_OFS_ENABLE  = 8'h04; // per-fault enable
	localparam logic [7:0] DFM_OFS_VDC_HI  = 8'h08; // motor bus upper level
	localparam logic [7:0] DFM_OFS_VDC_LO  = 8'h0C; // motor bus lower level
	localparam logic [7:0] DFM_OFS_PVDC_HI = 8'h10; // pfc bus upper level
	localparam logic [7:0] DFM_OFS_PVDC_LO = 8'h14; // pfc bus lower level
	localparam logic [7:0] DFM_OFS_VCRIT   = 8'h18; // critical bus level
	localparam logic [7:0] DFM_OFS_TEMP_HI = 8'h1C; // temperature level
	localparam logic [7:0] DFM_OFS_VAC_HI  = 8'h20; // ac upper level
	localparam logic [7:0] DFM_OFS_VAC_LO  = 8'h24; // ac lower level
	localparam logic [7:0] DFM_OFS_FREQ    = 8'h28; // nominal line frequency
	localparam logic [7:0] DFM_OFS_LINK_TO = 8'h2C; // uart silence limit
	localparam logic [7:0] DFM_OFS_HALL_TO = 8'h30; // hall edge limit
	localparam logic [7:0] DFM_OFS_CTRL    = 8'h34; // bit0 hall mode
	localparam logic [7:0] DFM_OFS_STATUS  = 8'h38; // output state

	// fault bit positions
	localparam int DFM_B_GKILL  = 0;
	localparam int DFM_B_CRITOV = 1;
	localparam int DFM_B_DCOV   = 2;
	localparam int DFM_B_DCUV   = 3;
	localparam int DFM_B_PLL    = 4;
	localparam int DFM_B_OVTEMP = 5;
	localparam int DFM_B_RLOCK  = 6;
	localparam int DFM_B_EXEC   = 7;
	localparam int DFM_B_PHLOSS = 8;
	localparam int DFM_B_PARAM  = 9;
	localparam int DFM_B_LINK   = 10;
	localparam int DFM_B_HALLIN = 11;
	localparam int DFM_B_HALLTO = 12;
	localparam int DFM_B_PGKILL = 13;
	localparam int DFM_B_PDCOV  = 14;
	localparam int DFM_B_PDCUV  = 15;
	localparam int DFM_B_PACOV  = 16;
	localparam int DFM_B_PACUV  = 17;
	localparam int DFM_B_PFREQ  = 18;
	localparam int DFM_B_PPARAM = 19;
	localparam int DFM_NFLT     = 20;

	// unmaskable faults ignore the enable register
	localparam logic [19:0] DFM_UNMASK = 20'h0_2003;

	// reset values
	localparam logic [19:0] DFM_RST_ENABLE = 20'hF_FFFF;
	localparam logic [15:0] DFM_RST_LEVEL  = 16'h0000;
	localparam logic [15:0] DFM_RST_MAXLVL = 16'hFFFF;
	localparam logic [31:0] DFM_RST_TIMEO  = 32'h0001_E848;

	// load above this percentage is an execution fault
	localparam logic [7:0] DFM_LOAD_LIMIT = 8'h5F;
	// valid hall codes are 1..6; 0 and 7 are illegal
	localparam logic [2:0] DFM_HALL_ZERO = 3'h0;
	localparam logic [2:0] DFM_HALL_SEVEN = 3'h7;

	// sensor inputs travelling together
	typedef struct packed {
		logic        mot_oc;     // motor over-current comparator
		logic        pfc_oc;     // pfc over-current comparator
		logic [15:0] vdc;        // motor bus voltage
		logic [15:0] pfc_vdc;    // pfc bus voltage
		logic [15:0] vac;        // ac input voltage
		logic [15:0] freq;       // measured line frequency
		logic [15:0] temp;       // temperature
		logic        pll_lost;   // flux pll out of lock
		logic        rotor_lock; // rotor stalled while driven
		logic [7:0]  cpu_load;   // load in percent
		logic        phase_open; // a motor phase is disconnected
		logic        par_bad;    // motor parameter block invalid
		logic        pfc_par_bad;// pfc parameter block invalid
		logic        uart_rx;    // one-cycle pulse per received byte
		logic [2:0]  hall;       // sampled hall inputs
	} dfm_sense_t;

endpackage

// *** test/dfm_chk.sv ***
/*
 checker for dfm_top: port-level assertions on pwm gating and bus timing.
 assumes it is bound to dfm_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module dfm_chk
	import dfm_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// sensors and pwm
	input wire dfm_sense_t  sense,
	input wire logic [2:0]  pwm_hi,
	input wire logic [2:0]  pwm_lo,
	input wire logic [1:0]  pfc_pwm,
	input wire logic        mot_shutdown,
	input wire logic        pfc_shutdown
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// a flag clear in flight, the only way besides over-current that braking may end
	logic wr_flags;
	logic brk;
	assign wr_flags = wb_cyc_i & wb_stb_i & wb_we_i
		& (wb_adr_i == DFM_OFS_FLAGS);
	assign brk = mot_shutdown & (pwm_lo == 3'h7) & (pwm_hi == 3'h0);
	property p_gkill;
		sense.mot_oc |=> mot_shutdown && pwm_hi == 3'h0 && pwm_lo == 3'h0;
	endproperty
	a_gkill: assert property (p_gkill) else $error("motor kill late");
	property p_sd_pat;
		mot_shutdown |-> pwm_hi == 3'h0 && (pwm_lo == 3'h0 || pwm_lo == 3'h7);
	endproperty
	a_sd_pat: assert property (p_sd_pat) else $error("bad stop pattern");
	property p_brk_hold;
		brk && !sense.mot_oc && !wr_flags && !$past(wr_flags) |=> brk;
	endproperty
	a_brk_hold: assert property (p_brk_hold) else $error("brake lost");
	property p_pkill;
		sense.pfc_oc |=> pfc_shutdown && pfc_pwm == 2'h0;
	endproperty
	a_pkill: assert property (p_pkill) else $error("pfc kill late");
	property p_psd;
		pfc_shutdown |-> pfc_pwm == 2'h0;
	endproperty
	a_psd: assert property (p_psd) else $error("pfc pwm leaks");
	property p_stick;
		$fell(sense.mot_oc) && !wr_flags && !$past(wr_flags) |=> mot_shutdown;
	endproperty
	a_stick: assert property (p_stick) else $error("kill not sticky");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	property p_dat0;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat0: assert property (p_dat0) else $error("data off ack");
	c_brk: cover property (brk);
	c_pkill: cover property (pfc_shutdown);
	c_clr: cover property (wr_flags && wb_ack_o);
endmodule

bind dfm_top dfm_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sense(sense), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .pfc_pwm(pfc_pwm),
	.mot_shutdown(mot_shutdown), .pfc_shutdown(pfc_shutdown));

// *** test/dfm_plant.sv ***
/*
 sensor and power stage model: nominal readings, a uart byte and a hall
 step every 8 cycles, and one fault condition chosen by inject.
 assumes the thresholds the bench programs (bus 0800..2000, crit 3000).
*/
`timescale 1ns/1ps
module dfm_plant
	import dfm_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// fault selector, 31 for none
	input  wire logic [4:0] inject,
	// sensor outputs
	output dfm_sense_t      sense
);
	logic [2:0] cnt;
	logic [2:0] hall_q;
	// hall walks the legal codes; stalls only when asked
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			cnt <= 3'h0;
			hall_q <= 3'h1;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			if (cnt == 3'h0 && inject != 5'd12)
				hall_q <= (hall_q == 3'h6) ? 3'h1 : hall_q + 3'h1;
		end
	// nominal values, then the one selected fault
	always_comb
	begin
		sense = '0;
		sense.vdc = 16'h1000;
		sense.pfc_vdc = 16'h1000;
		sense.vac = 16'h1000;
		sense.freq = 16'h0032;
		sense.temp = 16'h0050;
		sense.cpu_load = 8'h32;
		sense.hall = hall_q;
		sense.uart_rx = (cnt == 3'h0) && inject != 5'd10;
		case (inject)
			5'd0: sense.mot_oc = 1'b1;
			5'd1: sense.vdc = 16'h3001;
			5'd2: sense.vdc = 16'h2001;
			5'd3: sense.vdc = 16'h07FF;
			5'd4: sense.pll_lost = 1'b1;
			5'd5: sense.temp = 16'h0101;
			5'd6: sense.rotor_lock = 1'b1;
			5'd7: sense.cpu_load = 8'h60;
			5'd8: sense.phase_open = 1'b1;
			5'd9: sense.par_bad = 1'b1;
			5'd11: sense.hall = 3'h7;
			5'd13: sense.pfc_oc = 1'b1;
			5'd14: sense.pfc_vdc = 16'h2001;
			5'd15: sense.pfc_vdc = 16'h07FF;
			5'd16: sense.vac = 16'h2001;
			5'd17: sense.vac = 16'h07FF;
			5'd18: sense.freq = 16'h0033;
			5'd19: sense.pfc_par_bad = 1'b1;
			5'd20: sense.cpu_load = 8'h5F; // load at the limit is fine
			default: ;
		endcase
	end
endmodule

// *** test/dfm_top_tb.sv ***
/*
 testbench for dfm_top: wishbone register checks, every fault injected,
 sticky clear, braking hold and masking.
 assumes dfm_plant for sensors and dfm_chk bound to the design.
*/
`timescale 1ns/1ps
module dfm_top_tb;
	import dfm_pkg::*;
	logic clk_sys, reset_n, cyc, stb, we, ack, msd, psd;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q;
	logic [4:0] inject;
	logic [2:0] hi_req, lo_req, hi, lo;
	logic [1:0] pfc_req, pfc;
	dfm_sense_t sense;
	int fails, samples_checked;
	logic [7:0] ca[11] = '{DFM_OFS_VDC_HI, DFM_OFS_VDC_LO, DFM_OFS_PVDC_HI,
		DFM_OFS_PVDC_LO, DFM_OFS_VCRIT, DFM_OFS_TEMP_HI, DFM_OFS_VAC_HI,
		DFM_OFS_VAC_LO, DFM_OFS_FREQ, DFM_OFS_LINK_TO, DFM_OFS_HALL_TO};
	logic [31:0] cd[11] = '{32'h0000_2000, 32'h0000_0800, 32'h0000_2000,
		32'h0000_0800, 32'h0000_3000, 32'h0000_0100, 32'h0000_2000,
		32'h0000_0800, 32'h0000_0032, 32'h0000_0014, 32'h0000_0014};
	dfm_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sense(sense),
		.pwm_hi_req(hi_req), .pwm_lo_req(lo_req), .pfc_pwm_req(pfc_req),
		.pwm_hi(hi), .pwm_lo(lo), .pfc_pwm(pfc), .mot_shutdown(msd),
		.pfc_shutdown(psd));
	dfm_plant plant (.clk_sys(clk_sys), .reset_n(reset_n),
		.inject(inject), .sense(sense));
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; ack and read data are taken at the same rising
	// edge, and only then is the request released
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb, we} <= 3'b000;
		if (n >= 20)
		begin
			fails++;
			final_report;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	initial
	begin
		{cyc, stb, we, adr, dat, sel} = '0;
		{hi_req, lo_req, pfc_req} = '0;
		fails = 0;
		samples_checked = 0;
		inject = 5'd31;
		reset_n = 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		wb(0, DFM_OFS_ENABLE, 0); chk("enable", 32'h000F_FFFF, q);
		wb(0, DFM_OFS_VDC_HI, 0); chk("vdc_hi", 32'h0000_FFFF, q);
		wb(0, DFM_OFS_LINK_TO, 0); chk("link_to", DFM_RST_TIMEO, q);
		wb(0, 8'h3C, 0); chk("unmapped", 32'h0000_0000, q);
		foreach (ca[i]) wb(1, ca[i], cd[i]);
		wb(1, DFM_OFS_CTRL, 32'h0000_0001);
		wb(1, DFM_OFS_FLAGS, 32'h000F_FFFF);
		hi_req <= 3'h5;
		lo_req <= 3'h2;
		pfc_req <= 2'h3;
		wt(4);
		wb(0, DFM_OFS_FLAGS, 0); chk("flags idle", 32'h0000_0000, q);
		$display("register test done");
		// every fault in turn: set, outlive its cause, clear
		for (int b = 0; b < 20; b++)
		begin
			@(posedge clk_sys) inject <= b[4:0];
			wt(40);
			chk("mot_sd", {31'h0, b < 13}, {31'h0, msd});
			chk("pfc_sd", {31'h0, b >= 13}, {31'h0, psd});
			chk("pwm_hi", (b < 13) ? 32'h0 : 32'h5, {29'h0, hi});
			if (b != 1) chk("pwm_lo", (b < 13) ? 32'h0 : 32'h2, {29'h0, lo});
			chk("pfc_pwm", (b >= 13) ? 32'h0 : 32'h3, {30'h0, pfc});
			if (b == 1) chk("brake", 32'h7, {29'h0, lo});
			if (b == 1)
			begin
				wb(0, DFM_OFS_STATUS, 0);
				chk("status", 32'h5, q);
			end
			wb(0, DFM_OFS_FLAGS, 0); chk("set", 32'h1, {31'h0, q[b]});
			@(posedge clk_sys) inject <= 5'd31;
			wt(6);
			if (b == 1) chk("brake hold", 32'h7, {29'h0, lo});
			wb(0, DFM_OFS_FLAGS, 0); chk("sticky", 32'h1, {31'h0, q[b]});
			wb(1, DFM_OFS_FLAGS, 32'h000F_FFFF);
			wt(3);
			chk("pwm free", 32'h5, {29'h0, hi});
			chk("lo free", 32'h2, {29'h0, lo});
			chk("pfc free", 32'h3, {30'h0, pfc});
			wb(0, DFM_OFS_FLAGS, 0); chk("cleared", 32'h0, q);
			$display("fault %0d done", b);
		end
		@(posedge clk_sys) inject <= 5'd20;
		wt(10);
		wb(0, DFM_OFS_FLAGS, 0); chk("load 95", 32'h0, q);
		$display("load test done");
		// masked fault leaves pwm alone, over-current still kills
		wb(1, DFM_OFS_ENABLE, 32'h0000_0000);
		@(posedge clk_sys) inject <= 5'd2;
		wt(10);
		chk("masked", 32'h0, {31'h0, msd});
		chk("masked pwm", 32'h5, {29'h0, hi});
		@(posedge clk_sys) inject <= 5'd0;
		wt(4);
		chk("unmaskable", 32'h1, {31'h0, msd});
		$display("mask test done");
		final_report;
	end
endmodule
